// ===== pkg/tio_pkg.sv
package tio_pkg;
    // Bus and datapath sizes
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int CNT_W  = 16;
    localparam int NUM_CB = 6;
    localparam int SEL_W  = 3;
    localparam int SRC_W  = 5;
    localparam int DIV_W  = 8;
    localparam int CFG_W  = 16;
    localparam int ST_W   = 3;
    localparam int WID_W  = 3;
    localparam int COND_W = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_COND  = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_TIME  = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_DATA  = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_STAMP = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_STAT  = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_MASK  = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_CB1   = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_CBN   = 6'h30;

    // Control register fields
    localparam int CTL_EN     = 0;
    localparam int CTL_OUT    = 1;
    localparam int CTL_OC     = 2;
    localparam int CTL_INSTB  = 3;
    localparam int CTL_OUTSTB = 4;
    localparam int CTL_WID    = 5;
    localparam int CTL_COND   = 8;
    localparam int CTL_CLK    = 12;

    // Status and mask bit positions
    localparam int ST_XFER = 0;
    localparam int ST_COND = 1;
    localparam int ST_SENT = 2;

    // Clock block configuration fields
    localparam int CB_SRC = 0;
    localparam int CB_DIV = 8;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0;
    localparam logic [CFG_W-1:0]  CFG_RST  = 16'h0;
    localparam logic [SEL_W-1:0]  REF_CB   = 3'h0;

    typedef enum logic [WID_W-1:0] {
        WID_1, WID_4, WID_8, WID_16, WID_32
    } width_t;

    typedef enum logic [COND_W-1:0] {
        COND_NONE, COND_EQ, COND_NE
    } cond_t;
endpackage : tio_pkg

// ===== pkg/xfer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface xfer_if;
    logic                  tick;
    logic                  go;
    logic                  dirOut;
    tio_pkg::width_t       width;
    logic                  loadValid;
    logic [31:0]           loadData;
    logic                  loadReady;
    logic                  take;
    logic [31:0]           pinIn;
    logic [31:0]           outWord;
    logic [31:0]           xferData;
    logic                  xferFull;
    logic                  xferDone;
    logic                  step;

    modport serdes (
        input  tick, go, dirOut, width, loadValid, loadData, take, pinIn,
        output loadReady, outWord, xferData, xferFull, xferDone, step
    );
    modport ctrl (
        output tick, go, dirOut, width, loadValid, loadData, take, pinIn,
        input  loadReady, outWord, xferData, xferFull, xferDone, step
    );
endinterface : xfer_if

`default_nettype wire

// ===== tb/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic [31:0] pinOut,
    input  wire logic [31:0] pinOe,
    input  wire logic [31:0] extVal,
    output logic      [31:0] pinIn
);
    // Undriven pins show the far side; zero models the pull-down
    assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule : pin_partner
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tio_pkg::*;
    logic        clk, srst, rd, wr, irq, wReq, link, strobeIn, strobeOut, ev;
    logic [5:0]  addr;
    logic [31:0] wdat, rdat, pinIn, pinOut, pinOe, extVal, r, c1, narrow;
    int          nFail, checksDone;
    timed_io_port DUT (.clk(clk), .srst(srst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wReq), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .inbound_valid_strobe(strobeIn),
        .outbound_valid_strobe(strobeOut), .linkEnable(link),
        .narrowOwned(narrow), .portEvent(ev), .irq(irq));
    pin_partner far (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
        .pinIn(pinIn));
    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [5:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        rd   <= ~w;
        wr   <= w;
        do @(posedge clk); while (wReq !== 1'b0);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // Watchdog, far beyond the 120 or so cycles of the tests
    initial
    begin
        #300us;
        nFail++;
        give_verdict();
    end
    initial
    begin
        srst     <= 1'b1;
        rd       <= 1'b0;
        wr       <= 1'b0;
        addr     <= 6'h0;
        wdat     <= 32'h0;
        link     <= 1'b0;
        narrow   <= 32'h0;
        strobeIn <= 1'b0;
        extVal   <= 32'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        bus(OFF_CTRL, 1'b0, 32'h0);
        chk(r, 32'h0);
        chk(pinOe, 32'h0);
        $display("test reset done");
        bus(OFF_MASK, 1'b1, 32'h4);
        bus(OFF_CTRL, 1'b1, 32'h93);
        bus(OFF_DATA, 1'b1, 32'ha5c30f1e);
        // Outbound strobe stands for the one tick after the word goes out
        @(negedge clk);
        chk({31'h0, strobeOut}, 32'h0);
        @(negedge clk);
        chk({31'h0, strobeOut}, 32'h1);
        @(negedge clk);
        chk({31'h0, strobeOut}, 32'h0);
        repeat (4) @(posedge clk);
        chk(pinOut, 32'ha5c30f1e);
        chk(pinOe, 32'hffffffff);
        chk({31'h0, irq}, 32'h1);
        bus(OFF_STAT, 1'b1, 32'h4);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(OFF_COUNT, 1'b0, 32'h0);
        c1 = r;
        bus(OFF_COUNT, 1'b0, 32'h0);
        chk(r - c1, 32'h3);
        bus(6'h3c, 1'b0, 32'h0);
        chk(r, 32'h0);
        $display("test output done");
        bus(OFF_CTRL, 1'b1, 32'h87);
        bus(OFF_DATA, 1'b1, 32'h0000ffff);
        repeat (4) @(posedge clk);
        chk(pinOe, 32'hffff0000);
        chk(pinOut, 32'h0);
        // Pins owned by a narrower port drop out of this one
        narrow <= 32'h00ff0000;
        @(negedge clk);
        chk(pinOe, 32'hff000000);
        @(posedge clk);
        narrow <= 32'h0;
        link <= 1'b1;
        repeat (2) @(posedge clk);
        chk(pinOe, 32'h0);
        link <= 1'b0;
        $display("test open collector done");
        extVal <= 32'h12345678;
        bus(OFF_STAT, 1'b1, 32'h7);
        bus(OFF_CTRL, 1'b1, 32'h89);
        repeat (4) @(posedge clk);
        bus(OFF_STAT, 1'b0, 32'h0);
        chk(r & 32'h1, 32'h0);
        strobeIn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(OFF_DATA, 1'b0, 32'h0);
        chk(r, 32'h12345678);
        @(negedge clk);
        chk({31'h0, ev}, 32'h1);
        $display("test input done");
        // Equal condition met: samples and condition events keep coming
        bus(OFF_COND, 1'b1, 32'h12345678);
        bus(OFF_CTRL, 1'b1, 32'h189);
        bus(OFF_STAT, 1'b1, 32'h7);
        bus(OFF_STAT, 1'b0, 32'h0);
        chk(r & 32'h3, 32'h3);
        // Condition false: sampling held off, no events
        bus(OFF_COND, 1'b1, 32'h0);
        bus(OFF_STAT, 1'b1, 32'h7);
        repeat (2) @(posedge clk);
        bus(OFF_STAT, 1'b0, 32'h0);
        chk(r, 32'h0);
        @(negedge clk);
        chk({31'h0, ev}, 32'h0);
        $display("test condition done");
        // Block 1 from pin 0, divider one: every second rising edge ticks
        bus(OFF_CB1, 1'b1, 32'h0100);
        bus(OFF_CTRL, 1'b1, 32'h1000);
        bus(OFF_COUNT, 1'b0, 32'h0);
        c1 = r;
        repeat (4)
        begin
            extVal <= 32'h1;
            repeat (2) @(posedge clk);
            extVal <= 32'h0;
            repeat (2) @(posedge clk);
        end
        bus(OFF_COUNT, 1'b0, 32'h0);
        chk(r - c1, 32'h2);
        $display("test clock block done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire

// ===== verilog/port_serdes.sv
`timescale 1ns/1ps
`default_nettype none

module port_serdes (
    input wire logic clk,
    input wire logic srst,
    xfer_if.serdes   x
);
    import tio_pkg::*;

    logic [DATA_W-1:0] shift_reg;
    logic [DATA_W-1:0] xfer_reg;
    logic [DATA_W-1:0] out_reg;
    logic [5:0]        cnt_reg;
    logic              full_reg;
    logic              full_next;
    logic [5:0]        lastIdx;
    logic [DATA_W-1:0] inWord;
    logic [DATA_W-1:0] outShift;
    logic [DATA_W-1:0] src;
    logic              start;
    logic              shiftOn;
    logic              sample;
    logic              wordIn;
    logic              load;

    // A new word leaves the transfer register only on a go tick
    assign start   = x.dirOut & x.go & full_reg & (cnt_reg == 6'h00);
    assign shiftOn = x.dirOut & x.tick & (cnt_reg != 6'h00);
    assign sample  = ~x.dirOut & x.go;
    assign wordIn  = sample & (cnt_reg == lastIdx);
    assign load    = x.loadValid & ~full_reg;
    assign src     = start ? xfer_reg : shift_reg;

    // Step size by width; the word is always the full 32 bits
    always_comb
    begin
        unique case (x.width)
            WID_1:
            begin
                lastIdx  = 6'h1f;
                inWord   = {x.pinIn[0], shift_reg[31:1]};
                outShift = {1'h0, src[31:1]};
            end
            WID_4:
            begin
                lastIdx  = 6'h07;
                inWord   = {x.pinIn[3:0], shift_reg[31:4]};
                outShift = {4'h0, src[31:4]};
            end
            WID_8:
            begin
                lastIdx  = 6'h03;
                inWord   = {x.pinIn[7:0], shift_reg[31:8]};
                outShift = {8'h0, src[31:8]};
            end
            WID_16:
            begin
                lastIdx  = 6'h01;
                inWord   = {x.pinIn[15:0], shift_reg[31:16]};
                outShift = {16'h0, src[31:16]};
            end
            default:
            begin
                lastIdx  = 6'h00;
                inWord   = x.pinIn;
                outShift = 32'h0;
            end
        endcase
    end

    // A word landing wins over a take in the same cycle
    assign full_next = (wordIn | load) ? 1'b1 :
                       (start | x.take) ? 1'b0 : full_reg;

    // Shift register and transfer register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_reg <= 32'h0;
            xfer_reg  <= 32'h0;
            out_reg   <= 32'h0;
            cnt_reg   <= 6'h00;
            full_reg  <= 1'b0;
        end
        else
        begin
            full_reg <= full_next;
            if (start | shiftOn)
            begin
                out_reg   <= src;
                shift_reg <= outShift;
                cnt_reg   <= start ? lastIdx : 6'(cnt_reg - 6'h01);
            end
            else if (sample)
            begin
                shift_reg <= inWord;
                cnt_reg   <= wordIn ? 6'h00 : 6'(cnt_reg + 6'h01);
            end
            if (wordIn)
                xfer_reg <= inWord;
            else if (load)
                xfer_reg <= x.loadData;
        end
    end

    assign x.loadReady = ~full_reg;
    assign x.outWord   = out_reg;
    assign x.xferData  = xfer_reg;
    assign x.xferFull  = full_reg;
    assign x.xferDone  = start | wordIn;
    assign x.step      = start | shiftOn;
endmodule : port_serdes

`default_nettype wire

// ===== verilog/timed_io_port.sv
`timescale 1ns/1ps
`default_nettype none

module timed_io_port (
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic [tio_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [tio_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [tio_pkg::DATA_W-1:0]   avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic [tio_pkg::DATA_W-1:0]   pinIn,
    output logic      [tio_pkg::DATA_W-1:0]   pinOut,
    output logic      [tio_pkg::DATA_W-1:0]   pinOe,
    input  wire logic                         inbound_valid_strobe,
    output logic                              outbound_valid_strobe,
    input  wire logic                         linkEnable,
    input  wire logic [tio_pkg::DATA_W-1:0]   narrowOwned,
    output logic                              portEvent,
    output logic                              irq
);
    import tio_pkg::*;

    xfer_if x ();

    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] cond_reg;
    logic [CNT_W-1:0]  time_reg;
    logic              timeArm_reg;
    logic [CNT_W-1:0]  counter_reg;
    logic [CNT_W-1:0]  stamp_reg;
    logic [ST_W-1:0]   stat_reg;
    logic [ST_W-1:0]   stat_next;
    logic [ST_W-1:0]   mask_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic              rdAck_reg;
    logic              outStb_reg;
    logic              portEvent_reg;
    wire  [NUM_CB-1:0] cbTick;
    wire  [CFG_W-1:0]  cbRead [NUM_CB];

    logic              hitCtrl;
    logic              hitCond;
    logic              hitTime;
    logic              hitData;
    logic              hitCount;
    logic              hitStamp;
    logic              hitStat;
    logic              hitMask;
    logic              hitCb;
    logic [SEL_W-1:0]  cbIdx;
    logic              wrAcc;
    logic              rdTake;
    logic              stall;
    logic [DATA_W-1:0] rdMux;
    logic              portOn;
    logic              dirOut;
    logic              ocMode;
    logic              inStbEn;
    logic              outStbEn;
    width_t            width;
    cond_t             condMode;
    logic [SEL_W-1:0]  clkSel;
    logic              portTick;
    logic              tickOn;
    logic [DATA_W-1:0] widthMask;
    logic [DATA_W-1:0] avail;
    logic [DATA_W-1:0] pinVal;
    logic              condMet;
    logic              timeOk;
    logic              inOk;
    logic              condHit;
    logic [ST_W-1:0]   evt;

    // Byte-lane merge for partial Avalon writes
    function automatic logic [DATA_W-1:0] beMerge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0]        be
    );
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                res[8*b +: 8] = wdata[8*b +: 8];
        end
        return res;
    endfunction : beMerge

    port_serdes u_serdes (
        .clk  (clk),
        .srst (srst),
        .x    (x)
    );

    // Address decode
    assign hitCtrl  = (avs_address == OFF_CTRL);
    assign hitCond  = (avs_address == OFF_COND);
    assign hitTime  = (avs_address == OFF_TIME);
    assign hitData  = (avs_address == OFF_DATA);
    assign hitCount = (avs_address == OFF_COUNT);
    assign hitStamp = (avs_address == OFF_STAMP);
    assign hitStat  = (avs_address == OFF_STAT);
    assign hitMask  = (avs_address == OFF_MASK);
    assign hitCb    = (avs_address >= OFF_CB1) & (avs_address <= OFF_CBN)
                    & (avs_address[1:0] == 2'h0);
    assign cbIdx    = SEL_W'(avs_address[ADDR_W-1:2]
                    - OFF_CB1[ADDR_W-1:2]) + 3'h1;

    // Reads wait one cycle; data writes stall only while the port drains
    assign stall = avs_write & hitData & dirOut & portOn & ~x.loadReady;
    assign avs_waitrequest = (avs_read & ~rdAck_reg) | stall;
    assign wrAcc  = avs_write & ~avs_waitrequest;
    assign rdTake = avs_read & ~rdAck_reg & hitData & ~dirOut;

    // Read selection; unmapped words read zero
    assign rdMux = hitCtrl  ? ctrl_reg :
                   hitCond  ? cond_reg :
                   hitTime  ? DATA_W'(time_reg) :
                   hitData  ? x.xferData :
                   hitCount ? DATA_W'(counter_reg) :
                   hitStamp ? DATA_W'(stamp_reg) :
                   hitStat  ? DATA_W'(stat_reg) :
                   hitMask  ? DATA_W'(mask_reg) :
                   hitCb    ? DATA_W'(cbRead[cbIdx]) : 32'h0;

    // Control fields
    assign portOn   = ctrl_reg[CTL_EN] & ~linkEnable;
    assign dirOut   = ctrl_reg[CTL_OUT];
    assign ocMode   = ctrl_reg[CTL_OC];
    assign inStbEn  = ctrl_reg[CTL_INSTB];
    assign outStbEn = ctrl_reg[CTL_OUTSTB];
    assign width    = width_t'(ctrl_reg[CTL_WID +: WID_W]);
    assign condMode = cond_t'(ctrl_reg[CTL_COND +: COND_W]);
    assign clkSel   = ctrl_reg[CTL_CLK +: SEL_W];

    // Port follows its selected block; bad selections never tick
    assign portTick = (clkSel < SEL_W'(NUM_CB)) ? cbTick[clkSel] : 1'b0;
    assign tickOn   = portOn & portTick;

    // Pins the port owns at its width
    assign widthMask = (width == WID_1)  ? 32'h0000_0001 :
                       (width == WID_4)  ? 32'h0000_000f :
                       (width == WID_8)  ? 32'h0000_00ff :
                       (width == WID_16) ? 32'h0000_ffff :
                                           32'hffff_ffff;
    assign avail  = widthMask & ~narrowOwned
                  & {DATA_W{~linkEnable}};
    // Taken pins read zero, the word keeps its full width
    assign pinVal = pinIn & avail;

    // Conditional sampling, timed gate and inbound strobe
    assign condMet = (condMode == COND_NONE)
                   | ((condMode == COND_EQ) & (pinVal == (cond_reg & avail)))
                   | ((condMode == COND_NE)
                      & (pinVal != (cond_reg & avail)));
    assign timeOk  = ~timeArm_reg | (counter_reg == time_reg);
    assign inOk    = ~inStbEn | inbound_valid_strobe;
    assign condHit = tickOn & ~dirOut & timeOk & inOk
                   & (condMode != COND_NONE) & condMet;

    // Serdes hookup
    assign x.tick      = tickOn;
    assign x.go        = tickOn & timeOk
                       & (dirOut | (condMet & inOk));
    assign x.dirOut    = dirOut;
    assign x.width     = width;
    assign x.loadValid = wrAcc & hitData & dirOut;
    assign x.loadData  = avs_writedata;
    assign x.take      = rdTake;
    assign x.pinIn     = pinVal;

    // Open collector drives only zeros
    assign pinOe  = (portOn & dirOut)
                  ? (avail & (ocMode ? ~x.outWord : {DATA_W{1'b1}}))
                  : {DATA_W{1'b0}};
    assign pinOut = ocMode ? {DATA_W{1'b0}} : (x.outWord & avail);
    assign outbound_valid_strobe = outStb_reg & outStbEn & portOn;

    // Events, sticky status with set winning over a clear
    assign evt[ST_XFER] = x.xferDone & ~dirOut;
    assign evt[ST_COND] = condHit;
    assign evt[ST_SENT] = x.xferDone & dirOut;
    assign stat_next = (stat_reg & ~((wrAcc & hitStat)
                     ? avs_writedata[ST_W-1:0] : {ST_W{1'b0}})) | evt;
    assign irq          = |(stat_reg & mask_reg);
    assign portEvent    = portEvent_reg;
    assign avs_readdata = readdata_reg;

    // Reference block ticks every clk; others come from a pin
    assign cbTick[0] = 1'b1;
    assign cbRead[0] = CFG_RST;

    generate
        for (genvar g = 1; g < NUM_CB; g++)
        begin : g_cb
            logic [CFG_W-1:0] cfg_reg;
            logic             prev_reg;
            logic [DIV_W-1:0] div_reg;
            logic             srcPin;
            logic             edgeSeen;
            logic             divDone;
            logic             wrCfg;

            assign wrCfg    = wrAcc & hitCb & (cbIdx == SEL_W'(g));
            assign srcPin   = pinIn[cfg_reg[CB_SRC +: SRC_W]];
            assign edgeSeen = srcPin & ~prev_reg;
            assign divDone  = (div_reg == cfg_reg[CB_DIV +: DIV_W]);
            assign cbTick[g] = edgeSeen & divDone;
            assign cbRead[g] = cfg_reg;

            // Divide by field plus one rising edges
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    cfg_reg  <= CFG_RST;
                    prev_reg <= 1'b0;
                    div_reg  <= '0;
                end
                else
                begin
                    if (wrCfg)
                        cfg_reg <= CFG_W'(beMerge(DATA_W'(cfg_reg),
                                   avs_writedata, avs_byteenable));
                    prev_reg <= srcPin;
                    if (edgeSeen)
                        div_reg <= divDone ? '0 : DIV_W'(div_reg + 1'b1);
                end
            end
        end
    endgenerate

    // Software registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_reg    <= CTRL_RST;
            cond_reg    <= 32'h0;
            time_reg    <= 16'h0;
            timeArm_reg <= 1'b0;
            mask_reg    <= 3'h0;
            stat_reg    <= 3'h0;
        end
        else
        begin
            if (wrAcc & hitCtrl)
                ctrl_reg <= beMerge(ctrl_reg, avs_writedata, avs_byteenable);
            if (wrAcc & hitCond)
                cond_reg <= beMerge(cond_reg, avs_writedata, avs_byteenable);
            if (wrAcc & hitMask)
                mask_reg <= avs_writedata[ST_W-1:0];
            if (wrAcc & hitTime)
                time_reg <= avs_writedata[CNT_W-1:0];
            // Rearm on a new target, else drop after the timed transfer
            if (wrAcc & hitTime)
                timeArm_reg <= 1'b1;
            else if (x.xferDone)
                timeArm_reg <= 1'b0;
            stat_reg <= stat_next;
        end
    end

    // Port counter, timestamp and strobes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            counter_reg   <= 16'h0;
            stamp_reg     <= 16'h0;
            outStb_reg    <= 1'b0;
            portEvent_reg <= 1'b0;
        end
        else
        begin
            if (portTick)
                counter_reg <= CNT_W'(counter_reg + 1'b1);
            if (x.xferDone)
                stamp_reg <= counter_reg;
            if (x.step)
                outStb_reg <= 1'b1;
            else if (portTick)
                outStb_reg <= 1'b0;
            portEvent_reg <= evt[ST_XFER] | evt[ST_COND];
        end
    end

    // Bus read path
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdAck_reg    <= 1'b0;
            readdata_reg <= 32'h0;
        end
        else
        begin
            rdAck_reg <= avs_read & ~rdAck_reg;
            if (avs_read & ~rdAck_reg)
                readdata_reg <= rdMux;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_link_off;
        linkEnable |-> (pinOe == '0) && !x.go;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("port drives or moves data while link enabled");

    property p_owned;
        ((pinOe & narrowOwned) == '0) && ((pinOe & ~widthMask) == '0);
    endproperty
    a_owned: assert property (p_owned)
        else $error("port drives a pin it does not own");

    property p_opencoll;
        ocMode |-> (pinOut == '0) && ((pinOe & x.outWord) == '0);
    endproperty
    a_opencoll: assert property (p_opencoll)
        else $error("open collector drives a high level");

    property p_indir;
        !dirOut |-> (pinOe == '0) && !x.step;
    endproperty
    a_indir: assert property (p_indir)
        else $error("input port drives its pins");

    property p_count;
        portTick |=> counter_reg == CNT_W'($past(counter_reg) + 1'b1);
    endproperty
    a_count: assert property (p_count)
        else $error("counter did not step on a tick");

    property p_pins_on_tick;
        !x.step |=> $stable(x.outWord);
    endproperty
    a_pins_on_tick: assert property (p_pins_on_tick)
        else $error("output pins changed without a tick");

    property p_stamp;
        x.xferDone |=> stamp_reg == $past(counter_reg);
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("timestamp not taken at transfer");

    property p_timed;
        x.xferDone && timeArm_reg |-> counter_reg == time_reg;
    endproperty
    a_timed: assert property (p_timed)
        else $error("timed transfer at wrong count");

    property p_rst_clk;
        @(posedge clk) disable iff (1'b0)
        srst |=> (clkSel == REF_CB) && (counter_reg == '0);
    endproperty
    a_rst_clk: assert property (p_rst_clk)
        else $error("port not on reference block after reset");

    property p_strobe;
        inStbEn && !inbound_valid_strobe && !dirOut |-> !x.go;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("input sampled without inbound strobe");

    property p_event;
        condHit |=> portEvent && stat_reg[ST_COND];
    endproperty
    a_event: assert property (p_event)
        else $error("condition did not raise an event");

    property p_wr_fast;
        avs_write && !hitData |-> !avs_waitrequest;
    endproperty
    a_wr_fast: assert property (p_wr_fast)
        else $error("register write was stalled");
endmodule : timed_io_port

`default_nettype wire
